// ### inc/stf_pkg.sv
// constants for the torque filter and mode switch block
package stf_pkg;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 32;
  // byte offsets
  localparam logic [5:0]  OFS_MODE_SEL    = 6'h00;
  localparam logic [5:0]  OFS_ACCEL_THR   = 6'h04;
  localparam logic [5:0]  OFS_POSERR_THR  = 6'h08;
  localparam logic [5:0]  OFS_LAG_TC      = 6'h0c;
  localparam logic [5:0]  OFS_NOTCH_EN    = 6'h10;
  localparam logic [5:0]  OFS_N1_FREQ     = 6'h14;
  localparam logic [5:0]  OFS_N1_Q        = 6'h18;
  localparam logic [5:0]  OFS_N1_DEPTH    = 6'h1c;
  localparam logic [5:0]  OFS_N2_FREQ     = 6'h20;
  localparam logic [5:0]  OFS_N2_Q        = 6'h24;
  localparam logic [5:0]  OFS_N2_DEPTH    = 6'h28;
  localparam logic [5:0]  OFS_POS_INT_TC  = 6'h2c;
  localparam logic [5:0]  OFS_STATUS      = 6'h30;
  localparam logic [5:0]  NOTCH_STRIDE    = 6'h0c;
  // field positions
  localparam int          NOTCH1_EN_BIT   = 0;
  localparam int          NOTCH2_EN_BIT   = 8;
  localparam int          STAT_PONLY_BIT  = 0;
  localparam int          STAT_ACC_BIT    = 1;
  localparam int          STAT_PERR_BIT   = 2;
  // reset values
  localparam logic [2:0]  RST_MODE_SEL    = 3'h0;
  localparam logic [15:0] RST_ACCEL_THR   = 16'h0000;
  localparam logic [15:0] RST_POSERR_THR  = 16'h0000;
  localparam logic [15:0] RST_LAG_TC      = 16'h0064;
  localparam logic [15:0] RST_NOTCH_FREQ  = 16'h1388;
  localparam logic [15:0] RST_NOTCH_Q     = 16'h0046;
  localparam logic [15:0] RST_NOTCH_DEPTH = 16'h0000;
  localparam logic [15:0] RST_POS_INT_TC  = 16'h0000;
  // limits and scaling
  localparam logic [15:0] NOTCH_Q_MIN     = 16'h0032;
  localparam logic [15:0] DEPTH_FULL      = 16'h03e8;
  localparam int          FRAC_W          = 14;
  localparam longint      DAMP_NUM        = 64'd1638400;
  localparam longint      FCOEF_NUM       = 64'd1054;
  localparam int          FCOEF_SHIFT     = 10;
  // detection source selection
  typedef enum logic [2:0] {
    SEL_TORQUE = 3'h0,
    SEL_SPEED  = 3'h1,
    SEL_ACCEL  = 3'h2,
    SEL_POSERR = 3'h3,
    SEL_NONE   = 3'h4
  } stf_sel_t;
endpackage : stf_pkg

// ### src/stf_torque_filter_mode_switch.sv
// torque reference filter cascade, speed loop mode switch and position integral
// Notes on behaviour
// - accel above threshold forces proportional-only
// - position error above threshold forces proportional-only
// - position error test only in position control
// - lag and notch stages in series, independent
// - lag time constant 0..65535, default 100
// - notch one bypassed unless enabled, default off
// - notch two enabled separately, default off
// - notch one frequency 50..5000, default 5000
// - notch one quality 50..1000, default 70
// - notch one depth 0..1000, default 0
// - notch two has own frequency, quality, depth
// - position loop gets an integral term
// - position integral constant 0..50000, default 0
// - selection digit picks detection source
// - position error threshold 0..10000, default 0
// - integral-proportional mode disables mode switch
`timescale 1ns/1ns
`default_nettype none
module stf_torque_filter_mode_switch
  import stf_pkg::*;
#(
  parameter int SAMPLE_TS = 2
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      clkEn,
  input  wire logic [stf_pkg::ADDR_W-1:0] avsAddress,
  input  wire logic                      avsRead,
  input  wire logic                      avsWrite,
  input  wire logic [stf_pkg::DATA_W-1:0] avsWritedata,
  output logic      [stf_pkg::DATA_W-1:0] avsReaddata,
  output logic                           avsWaitrequest,
  input  wire logic                      sampleValid,
  input  wire logic signed [15:0]        torqueRef,
  input  wire logic signed [15:0]        accelCmd,
  input  wire logic signed [31:0]        posErr,
  input  wire logic signed [15:0]        speedErr,
  input  wire logic                      torqueLevelHit,
  input  wire logic                      speedLevelHit,
  input  wire logic                      posControl,
  input  wire logic                      ipMode,
  output logic signed [15:0]             torqueFiltered,
  output logic                           propOnly,
  output logic signed [31:0]             speedInteg,
  output logic signed [31:0]             posIntegTerm
);
  import stf_pkg::*;

  logic [2:0]         modeSel;
  logic [15:0]        accelThr;
  logic [15:0]        posErrThr;
  logic [15:0]        lagTc;
  logic [1:0]         notchEn;
  logic [15:0]        notchFreq [2];
  logic [15:0]        notchQ [2];
  logic [15:0]        notchDepth [2];
  logic [15:0]        posIntTc;
  logic signed [31:0] lagY;
  logic signed [31:0] svLow [2];
  logic signed [31:0] svBand [2];
  logic signed [31:0] posAcc;

  // bus decode
  wire busReq   = avsRead | avsWrite;
  wire wrCommit = clkEn & avsWrite & ~avsWaitrequest;
  wire wrMode   = wrCommit & (avsAddress == OFS_MODE_SEL);
  wire wrAccel  = wrCommit & (avsAddress == OFS_ACCEL_THR);
  wire wrPerr   = wrCommit & (avsAddress == OFS_POSERR_THR);
  wire wrLag    = wrCommit & (avsAddress == OFS_LAG_TC);
  wire wrEn     = wrCommit & (avsAddress == OFS_NOTCH_EN);
  wire wrPint   = wrCommit & (avsAddress == OFS_POS_INT_TC);
  wire [15:0] wrHalf = avsWritedata[15:0];

  // mode switch detection
  wire [15:0] accelMag = accelCmd[15] ? 16'(-accelCmd) : 16'(accelCmd);
  wire [31:0] posMag   = posErr[31] ? 32'(-posErr) : 32'(posErr);
  wire accelHit = accelMag > accelThr;
  wire perrHit  = posControl & (posMag > {16'h0000, posErrThr});
  logic selHit;
  always_comb begin
    unique case (stf_sel_t'(modeSel))
      SEL_TORQUE: selHit = torqueLevelHit;
      SEL_SPEED:  selHit = speedLevelHit;
      SEL_ACCEL:  selHit = accelHit;
      SEL_POSERR: selHit = perrHit;
      default:    selHit = 1'b0;
    endcase
  end
  wire next_propOnly = selHit & ~ipMode;

  // lag stage: y += (x - y) * Ts / (tc + Ts); tc of zero passes x
  wire signed [31:0] lagIn   = 32'(torqueRef);
  wire signed [47:0] lagStep = 48'(lagIn - lagY) * 48'(SAMPLE_TS);
  wire signed [47:0] lagDen  = 48'({16'h0000, lagTc}) + 48'(SAMPLE_TS);
  wire signed [31:0] next_lagY = (lagTc == 16'h0000) ? lagIn :
                                 32'(48'(lagY) + lagStep / lagDen);

  // notch stages as state-variable filters in Q14
  logic signed [31:0] stageIn  [3];
  logic signed [31:0] next_low [2];
  logic signed [31:0] next_band[2];
  assign stageIn[0] = next_lagY;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_notch
      wire [15:0] qSat = (notchQ[gi] < NOTCH_Q_MIN) ? NOTCH_Q_MIN : notchQ[gi];
      wire [15:0] dSat = (notchDepth[gi] > DEPTH_FULL) ? DEPTH_FULL : notchDepth[gi];
      wire signed [63:0] fCoef =
        64'((64'(notchFreq[gi]) * 64'(SAMPLE_TS) * FCOEF_NUM) >>> FCOEF_SHIFT);
      wire signed [63:0] damp  = 64'(DAMP_NUM / 64'(qSat));
      wire signed [63:0] x     = 64'(stageIn[gi]);
      wire signed [63:0] lowN  = 64'(svLow[gi]) + ((fCoef * 64'(svBand[gi])) >>> FRAC_W);
      wire signed [63:0] dmpB  = (damp * 64'(svBand[gi])) >>> FRAC_W;
      wire signed [63:0] high  = x - lowN - dmpB;
      wire signed [63:0] bandN = 64'(svBand[gi]) + ((fCoef * high) >>> FRAC_W);
      // depth of zero removes the full band, full depth removes none
      wire signed [63:0] cut   =
        (dmpB * $signed(64'(DEPTH_FULL - dSat))) / $signed(64'(DEPTH_FULL));
      wire en = notchEn[gi];
      assign next_low[gi]    = en ? 32'(lowN) : 32'sh0;
      assign next_band[gi]   = en ? 32'(bandN) : 32'sh0;
      assign stageIn[gi + 1] = en ? 32'(x - cut) : stageIn[gi];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          notchFreq[gi]  <= RST_NOTCH_FREQ;
          notchQ[gi]     <= RST_NOTCH_Q;
          notchDepth[gi] <= RST_NOTCH_DEPTH;
          svLow[gi]      <= 32'sh0;
          svBand[gi]     <= 32'sh0;
        end else if (clkEn) begin
          // parameters apply on the next sample
          if (wrCommit && avsAddress == OFS_N1_FREQ + 6'(gi) * NOTCH_STRIDE)
            notchFreq[gi] <= wrHalf;
          if (wrCommit && avsAddress == OFS_N1_Q + 6'(gi) * NOTCH_STRIDE)
            notchQ[gi] <= wrHalf;
          if (wrCommit && avsAddress == OFS_N1_DEPTH + 6'(gi) * NOTCH_STRIDE)
            notchDepth[gi] <= wrHalf;
          if (sampleValid) begin
            svLow[gi]  <= next_low[gi];
            svBand[gi] <= next_band[gi];
          end
        end
      end
    end
  endgenerate

  wire signed [31:0] outFull = stageIn[2];
  wire signed [15:0] next_torqueFiltered =
    (outFull > 32'sh00007fff) ? 16'sh7fff :
    (outFull < -32'sh00008000) ? -16'sh8000 : 16'(outFull);

  // position integral: accumulated error scaled by Ts / tc, tc of zero disables
  wire signed [31:0] next_posAcc = (posIntTc == 16'h0000) ? 32'sh0 : posAcc + posErr;
  wire signed [47:0] posScaled  = 48'(next_posAcc) * 48'(SAMPLE_TS);
  wire signed [31:0] next_posIntegTerm = (posIntTc == 16'h0000) ? 32'sh0 :
                                         32'(posScaled / $signed(48'({32'h0, posIntTc})));

  // read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    unique case (avsAddress)
      OFS_MODE_SEL:   rdMux = {29'h0, modeSel};
      OFS_ACCEL_THR:  rdMux = {16'h0, accelThr};
      OFS_POSERR_THR: rdMux = {16'h0, posErrThr};
      OFS_LAG_TC:     rdMux = {16'h0, lagTc};
      OFS_NOTCH_EN:   rdMux = {23'h0, notchEn[1], 7'h0, notchEn[0]};
      OFS_N1_FREQ:    rdMux = {16'h0, notchFreq[0]};
      OFS_N1_Q:       rdMux = {16'h0, notchQ[0]};
      OFS_N1_DEPTH:   rdMux = {16'h0, notchDepth[0]};
      OFS_N2_FREQ:    rdMux = {16'h0, notchFreq[1]};
      OFS_N2_Q:       rdMux = {16'h0, notchQ[1]};
      OFS_N2_DEPTH:   rdMux = {16'h0, notchDepth[1]};
      OFS_POS_INT_TC: rdMux = {16'h0, posIntTc};
      OFS_STATUS:     rdMux = {29'h0, perrHit, accelHit, propOnly};
      default:        rdMux = 32'h0;
    endcase
  end

  // bus slave: one wait cycle, write lands on the edge waitrequest is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h0;
    end else if (clkEn) begin
      if (busReq && avsWaitrequest) begin
        avsWaitrequest <= 1'b0;
        avsReaddata    <= avsRead ? rdMux : 32'h0;
      end else begin
        avsWaitrequest <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeSel   <= RST_MODE_SEL;
      accelThr  <= RST_ACCEL_THR;
      posErrThr <= RST_POSERR_THR;
      lagTc     <= RST_LAG_TC;
      notchEn   <= 2'b00;
      posIntTc  <= RST_POS_INT_TC;
    end else if (clkEn) begin
      if (wrMode)  modeSel   <= avsWritedata[2:0];
      if (wrAccel) accelThr  <= wrHalf;
      if (wrPerr)  posErrThr <= wrHalf;
      if (wrLag)   lagTc     <= wrHalf;
      if (wrEn)    notchEn   <= {avsWritedata[NOTCH2_EN_BIT], avsWritedata[NOTCH1_EN_BIT]};
      if (wrPint)  posIntTc  <= wrHalf;
    end
  end

  // control loop state: propOnly every enabled cycle, the rest advanced once per sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lagY           <= 32'sh0;
      torqueFiltered <= 16'sh0;
      propOnly       <= 1'b0;
      speedInteg     <= 32'sh0;
      posAcc         <= 32'sh0;
      posIntegTerm   <= 32'sh0;
    end else if (clkEn) begin
      propOnly <= next_propOnly;
      if (sampleValid) begin
        lagY           <= next_lagY;
        torqueFiltered <= next_torqueFiltered;
        if (!propOnly)
          speedInteg <= speedInteg + 32'(speedErr);
        posAcc         <= next_posAcc;
        posIntegTerm   <= next_posIntegTerm;
      end
    end
  end
endmodule : stf_torque_filter_mode_switch
`default_nettype wire

// ### tb/stf_monitor.sv
// concurrent checks on the ports of the torque filter and mode switch block
`timescale 1ns/1ns
`default_nettype none
module stf_monitor
  import stf_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       clkEn,
  input wire logic [stf_pkg::ADDR_W-1:0] avsAddress,
  input wire logic                       avsRead,
  input wire logic                       avsWrite,
  input wire logic [stf_pkg::DATA_W-1:0] avsReaddata,
  input wire logic                       avsWaitrequest,
  input wire logic                       sampleValid,
  input wire logic signed [15:0]         accelCmd,
  input wire logic signed [31:0]         posErr,
  input wire logic                       torqueLevelHit,
  input wire logic                       speedLevelHit,
  input wire logic                       posControl,
  input wire logic                       ipMode,
  input wire logic signed [15:0]         torqueFiltered,
  input wire logic                       propOnly,
  input wire logic signed [31:0]         speedInteg,
  input wire logic signed [31:0]         posIntegTerm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property (clkEn && !avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_accept_a: assert property (clkEn && (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("request not answered in the next cycle");
  unmapped_read_a: assert property (clkEn && avsRead && avsWaitrequest && avsAddress > 6'h30 |=> avsReaddata == 32'h0)
    else $error("unmapped read gave nonzero data");
  ip_off_a: assert property (clkEn && ipMode |=> !propOnly)
    else $error("proportional-only while integral-proportional selected");
  quiet_inputs_a: assert property (clkEn && !torqueLevelHit && !speedLevelHit && accelCmd == 16'sh0 && (posErr == 32'sh0 || !posControl) |=> !propOnly)
    else $error("proportional-only with no detection cause");
  integ_hold_a: assert property (clkEn && propOnly && sampleValid |=> $stable(speedInteg))
    else $error("speed integrator moved while proportional-only");
  torque_hold_a: assert property (clkEn && !sampleValid |=> $stable(torqueFiltered))
    else $error("filter output changed without a sample");
  posint_hold_a: assert property (clkEn && !sampleValid |=> $stable(posIntegTerm))
    else $error("position integral changed without a sample");
  cover property ($rose(propOnly));
  cover property (clkEn && avsRead && !avsWaitrequest);
  cover property (clkEn && sampleValid && propOnly);
endmodule : stf_monitor
bind stf_torque_filter_mode_switch stf_monitor stf_monitor_inst (.clk, .rst_n, .clkEn, .avsAddress,
  .avsRead, .avsWrite, .avsReaddata, .avsWaitrequest, .sampleValid, .accelCmd, .posErr,
  .torqueLevelHit, .speedLevelHit, .posControl, .ipMode, .torqueFiltered, .propOnly,
  .speedInteg, .posIntegTerm);
`default_nettype wire

// ### tb/stf_torque_filter_mode_switch_tb.sv
// self-checking bench for the torque filter and mode switch block
`timescale 1ns/1ns
`default_nettype none
module stf_torque_filter_mode_switch_tb;
  import stf_pkg::*;
  logic clk, rst_n, clkEn, avsRead, avsWrite, avsWaitrequest, sampleValid, posControl, ipMode;
  logic torqueLevelHit, speedLevelHit, propOnly;
  logic [ADDR_W-1:0] avsAddress;
  logic [DATA_W-1:0] avsWritedata, avsReaddata, rd;
  logic signed [15:0] torqueRef, accelCmd, speedErr, torqueFiltered;
  logic signed [31:0] posErr, speedInteg, posIntegTerm, held;
  int n_fail = 0;
  int n_checks = 0;
  // address, reset value, value written back
  localparam logic [39:0] ROWS [12] = '{40'h0000000002, 40'h0400007530, 40'h0800002710,
    40'h0c0064ffff, 40'h1000000101, 40'h1413880032, 40'h18004603e8, 40'h1c000003e8,
    40'h2013880032, 40'h2400460032, 40'h28000003e8, 40'h2c0000c350};
  stf_torque_filter_mode_switch stf_torque_filter_mode_switch_inst (.clk, .rst_n, .clkEn,
    .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsReaddata, .avsWaitrequest,
    .sampleValid, .torqueRef, .accelCmd, .posErr, .speedErr, .torqueLevelHit, .speedLevelHit,
    .posControl, .ipMode, .torqueFiltered, .propOnly, .speedInteg, .posIntegTerm);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= wd;
    avsWrite <= we;
    avsRead <= !we;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 100);
    if (n >= 100) n_fail++;
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus
  task automatic po(input logic signed [15:0] acc, input logic signed [31:0] pe,
                    input logic pc, input logic ip, input logic exp);
    @(posedge clk);
    accelCmd <= acc;
    posErr <= pe;
    posControl <= pc;
    ipMode <= ip;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("propOnly", {31'h0, exp}, {31'h0, propOnly});
  endtask : po
  task automatic smp(input logic signed [15:0] t);
    @(posedge clk);
    sampleValid <= 1'b1;
    torqueRef <= t;
    @(posedge clk);
    sampleValid <= 1'b0;
    @(negedge clk);
  endtask : smp
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {rst_n, avsRead, avsWrite, sampleValid, posControl, ipMode} = '0;
    {torqueLevelHit, speedLevelHit, avsAddress, avsWritedata} = '0;
    {torqueRef, accelCmd, posErr} = '0;
    clkEn = 1'b1;
    speedErr = 16'sd100;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      bus(1'b0, ROWS[i][37:32], 32'h0);
      chk("reset value", {16'h0, ROWS[i][31:16]}, rd);
      bus(1'b1, ROWS[i][37:32], {16'h0, ROWS[i][15:0]});
      bus(1'b0, ROWS[i][37:32], 32'h0);
      chk("readback", {16'h0, ROWS[i][15:0]}, rd);
    end
    $display("test register table done");
    bus(1'b1, OFS_LAG_TC, 32'h0);
    bus(1'b1, OFS_NOTCH_EN, 32'h0);
    smp(16'sh1234);
    chk("torqueFiltered", 32'h1234, 32'(torqueFiltered));
    bus(1'b1, OFS_NOTCH_EN, 32'h101);
    smp(-16'sh1234);
    chk("full depth notch", 32'hffffedcc, 32'(torqueFiltered));
    bus(1'b1, OFS_NOTCH_EN, 32'h0);
    bus(1'b1, OFS_LAG_TC, 32'd2);
    smp(16'sh0);
    chk("lag step", 32'hfffff6e6, 32'(torqueFiltered));
    @(posedge clk);
    clkEn <= 1'b0;
    held = 32'(torqueFiltered);
    smp(16'sh0100);
    chk("frozen output", held, 32'(torqueFiltered));
    @(posedge clk);
    clkEn <= 1'b1;
    $display("test bypass cascade done");
    bus(1'b1, OFS_ACCEL_THR, 32'd100);
    po(16'sd101, 0, 1'b0, 1'b0, 1'b1);
    held = speedInteg;
    smp(16'sh0);
    chk("speedInteg", held, speedInteg);
    po(-16'sd101, 0, 1'b0, 1'b0, 1'b1);
    po(16'sd100, 0, 1'b0, 1'b0, 1'b0);
    held = speedInteg;
    smp(16'sh0);
    chk("speedInteg run", held + 32'sd100, speedInteg);
    $display("test accel switch done");
    bus(1'b1, OFS_MODE_SEL, 32'h3);
    bus(1'b1, OFS_POSERR_THR, 32'd50);
    po(0, 32'sd51, 1'b1, 1'b0, 1'b1);
    po(0, -32'sd51, 1'b1, 1'b0, 1'b1);
    po(0, 32'sd50, 1'b1, 1'b0, 1'b0);
    po(0, 32'sd51, 1'b0, 1'b0, 1'b0);
    po(0, 32'sd51, 1'b1, 1'b1, 1'b0);
    bus(1'b1, OFS_MODE_SEL, 32'h4);
    po(0, 32'sd51, 1'b1, 1'b0, 1'b0);
    $display("test position error switch done");
    bus(1'b1, OFS_POS_INT_TC, 32'd4);
    smp(16'sh0);
    chk("posIntegTerm", 32'd25, posIntegTerm);
    @(posedge clk);
    posErr <= -32'sd153;
    smp(16'sh0);
    chk("posIntegTerm neg", 32'hffffffcd, posIntegTerm);
    $display("test position integral done");
    bus(1'b1, 6'h34, 32'hffff);
    bus(1'b0, 6'h34, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1'b1, OFS_MODE_SEL, 32'h2);
    po(16'sd101, 0, 1'b0, 1'b0, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h3, rd);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk("waitrequest in reset", 32'h1, {31'h0, avsWaitrequest});
    chk("propOnly in reset", 32'h0, {31'h0, propOnly});
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_LAG_TC, 32'h0);
    chk("lag default", 32'h64, rd);
    po(16'sd101, 0, 1'b0, 1'b0, 1'b0);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : stf_torque_filter_mode_switch_tb
`default_nettype wire
